/* include/dffsc_consts.svh */
// Constants for the dual set/clear storage element block
`ifndef DFFSC_CONSTS_SVH
`define DFFSC_CONSTS_SVH

// ********************************************************************
// Structure
// ********************************************************************
`define DFFSC_NUM_ELEM      2

// ********************************************************************
// Reset values
// ********************************************************************
`define DFFSC_RST_STORED    1'b0
`define DFFSC_RST_TRUE      1'b0
`define DFFSC_RST_COMP      1'b1
`define DFFSC_RST_CLK_PREV  1'b1

`endif

/* include/dffsc_pkg.sv */
// Types shared by the dual set/clear storage element block
`default_nettype none
`include "dffsc_consts.svh"

package dffsc_pkg;

    // ****************************************************************
    // Pin groups of one element
    // ****************************************************************
    typedef struct packed {
        logic elem_clock;
        logic data;
        logic set_n;
        logic async_reset_n;
    } dffsc_pins_type;

    typedef struct packed {
        logic q;
        logic q_n;
    } dffsc_outs_type;

    // Control situation of one element in a given cycle
    typedef enum logic [1:0] {
        DFFSC_CAPTURE,
        DFFSC_FORCE_SET,
        DFFSC_FORCE_CLEAR,
        DFFSC_FORCE_BOTH
    } dffsc_mode_type;

endpackage

`default_nettype wire

/* logic/dffsc_edge.sv */
// Rising-edge detector for one element clock pin
`timescale 1ns/10ps
`default_nettype none
`include "dffsc_consts.svh"

module dffsc_edge
    import dffsc_pkg::*;
(
    input  wire logic clock,
    input  wire logic rst,
    input  wire logic pin,
    output var  logic rise
);

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        logic prev;
    } dffsc_edge_state_type;

    dffsc_edge_state_type state;
    dffsc_edge_state_type next_state;

    // Previous level follows the pin every cycle
    always_comb begin
        next_state      = state;
        next_state.prev = pin;
    end

    // Reset to high so a pin already high at release is no edge
    always_ff @(posedge clock) begin
        if (rst) begin
            state.prev <= `DFFSC_RST_CLK_PREV;
        end else begin
            state <= next_state;
        end
    end

    // Edge pulse, one cycle wide
    assign rise = pin & ~state.prev;

endmodule // dffsc_edge

`default_nettype wire

/* logic/dffsc_top.sv */
// Two independent storage elements with set and clear overrides
`timescale 1ns/10ps
`default_nettype none
`include "dffsc_consts.svh"

module dffsc_top
    import dffsc_pkg::*;
(
    input  wire logic                                   clock,
    input  wire logic                                   rst,
    input  wire dffsc_pins_type [`DFFSC_NUM_ELEM-1:0]   elem_in,
    output var  dffsc_outs_type [`DFFSC_NUM_ELEM-1:0]   elem_out
);

    // ****************************************************************
    // Helpers
    // ****************************************************************

    // Classify the two overrides of one element
    function automatic dffsc_mode_type mode_of(input dffsc_pins_type p);
        dffsc_mode_type m;
        m = DFFSC_CAPTURE;
        case ({p.set_n, p.async_reset_n})
            2'h0:    m = DFFSC_FORCE_BOTH;
            2'h1:    m = DFFSC_FORCE_SET;
            2'h2:    m = DFFSC_FORCE_CLEAR;
            default: m = DFFSC_CAPTURE;
        endcase
        return m;
    endfunction

    // Output pair that shows a stored bit
    function automatic dffsc_outs_type show(input logic bit_val);
        dffsc_outs_type o;
        o.q   = bit_val;
        o.q_n = ~bit_val;
        return o;
    endfunction

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        logic           [`DFFSC_NUM_ELEM-1:0] stored;
        dffsc_outs_type [`DFFSC_NUM_ELEM-1:0] outs;
    } dffsc_top_state_type;

    dffsc_top_state_type               state;
    dffsc_top_state_type               next_state;
    logic [`DFFSC_NUM_ELEM-1:0]        rise;

    // ****************************************************************
    // Edge detection, one detector per element clock
    // ****************************************************************
    genvar gi;
    generate
        for (gi = 0; gi < `DFFSC_NUM_ELEM; gi++) begin : g_edge
            // Each element watches only its own clock pin
            dffsc_edge u_edge (
                .clock (clock),
                .rst   (rst),
                .pin   (elem_in[gi].elem_clock),
                .rise  (rise[gi])
            );
        end
    endgenerate

    // ****************************************************************
    // Next-state logic
    // ****************************************************************

    // Elements are computed in a loop over their own pins only
    always_comb begin
        next_state = state;
        for (int i = 0; i < `DFFSC_NUM_ELEM; i++) begin
            case (mode_of(elem_in[i]))
                DFFSC_FORCE_SET: begin
                    next_state.stored[i] = 1'b1;
                    next_state.outs[i]   = show(1'b1);
                end
                DFFSC_FORCE_CLEAR: begin
                    next_state.stored[i] = 1'b0;
                    next_state.outs[i]   = show(1'b0);
                end
                DFFSC_FORCE_BOTH: begin
                    // Both high; the stored bit is left alone so release
                    // shows the last value instead of an arbitrary one
                    next_state.outs[i].q   = 1'b1;
                    next_state.outs[i].q_n = 1'b1;
                end
                DFFSC_CAPTURE: begin
                    if (rise[i]) begin
                        next_state.stored[i] = elem_in[i].data;
                        next_state.outs[i]   = show(elem_in[i].data);
                    end else begin
                        // No edge: data pin is ignored
                        next_state.outs[i] = show(state.stored[i]);
                    end
                end
                default: begin
                    next_state.outs[i] = show(state.stored[i]);
                end
            endcase
        end
    end

    // ****************************************************************
    // Registers
    // ****************************************************************

    // Synchronous reset clears every element
    always_ff @(posedge clock) begin
        if (rst) begin
            for (int i = 0; i < `DFFSC_NUM_ELEM; i++) begin
                state.stored[i]     <= `DFFSC_RST_STORED;
                state.outs[i].q     <= `DFFSC_RST_TRUE;
                state.outs[i].q_n   <= `DFFSC_RST_COMP;
            end
        end else begin
            state <= next_state;
        end
    end

    // Outputs straight from the state flops
    assign elem_out = state.outs;

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);

    generate
        for (gi = 0; gi < `DFFSC_NUM_ELEM; gi++) begin : g_chk

            // Both overrides released and no edge this cycle
            sequence s_idle;
                elem_in[gi].set_n && elem_in[gi].async_reset_n && !rise[gi];
            endsequence

            // Set alone applied
            sequence s_set;
                !elem_in[gi].set_n && elem_in[gi].async_reset_n;
            endsequence

            // Clear alone applied
            sequence s_clear;
                elem_in[gi].set_n && !elem_in[gi].async_reset_n;
            endsequence

            // Edge taken with both overrides released
            sequence s_capture;
                elem_in[gi].set_n && elem_in[gi].async_reset_n && rise[gi];
            endsequence

            chk_set_force: assert property (
                s_set |=> elem_out[gi].q && !elem_out[gi].q_n)
                else $error("set did not force outputs high and low");

            chk_set_release: assert property (
                s_set ##1 s_idle [*2] |=> elem_out[gi].q && !elem_out[gi].q_n)
                else $error("set value lost after release");

            chk_clear_force: assert property (
                s_clear |=> !elem_out[gi].q && elem_out[gi].q_n)
                else $error("clear did not force outputs low and high");

            chk_clear_release: assert property (
                s_clear ##1 s_idle |=> !elem_out[gi].q)
                else $error("clear value lost after release");

            chk_data_capture: assert property (
                s_capture |=> elem_out[gi].q == $past(elem_in[gi].data)
                          && elem_out[gi].q_n == !$past(elem_in[gi].data))
                else $error("rising edge did not take data");

            chk_both_low: assert property (
                !elem_in[gi].set_n && !elem_in[gi].async_reset_n
                |=> elem_out[gi].q && elem_out[gi].q_n)
                else $error("both overrides low did not drive both high");

            chk_both_release: assert property (
                s_idle ##1 (!elem_in[gi].set_n && !elem_in[gi].async_reset_n)
                ##1 s_idle |=> elem_out[gi].q_n == !elem_out[gi].q)
                else $error("both-high output state was retained");

            chk_hold_value: assert property (
                s_idle ##1 s_idle |=> $stable(elem_out[gi].q)
                                   && $stable(elem_out[gi].q_n))
                else $error("stored value changed without an edge");

            chk_hold_after_capture: assert property (
                s_capture ##1 s_idle [*3] |=>
                    elem_out[gi].q == $past(elem_in[gi].data, 4))
                else $error("captured bit not held between edges");
        end
    endgenerate

    // Element 0 output must not move while only element 1 pins act
    chk_no_cross: assert property (
        (elem_in[0].set_n && elem_in[0].async_reset_n && !rise[0]) [*2]
        |=> $stable(elem_out[0]))
        else $error("element 0 changed without its own cause");

    // Element 1 forced or clocked while element 0 idles must leave element 0 alone
    chk_quiet_neighbour: assert property (
        (elem_in[0].set_n && elem_in[0].async_reset_n && !rise[0]) [*2]
        ##0 (rise[1] || !elem_in[1].set_n || !elem_in[1].async_reset_n)
        |=> $stable(elem_out[0]))
        else $error("element 1 activity disturbed element 0");

endmodule // dffsc_top

`default_nettype wire

/* tb/dffsc_board.sv */
// Board logic model that drives the pins of one storage element
`timescale 1ns/10ps
`default_nettype none

module dffsc_board
    import dffsc_pkg::*;
(
    input  wire dffsc_pins_type req,
    input  wire logic           allow_both,
    output var  dffsc_pins_type pins
);
    // ****************************************************************
    // Pin drive
    // ****************************************************************
    // Both overrides low only when a test asks for it; otherwise keep clear off
    always_comb begin
        pins = req;
        if (!req.set_n && !req.async_reset_n && !allow_both) begin
            pins.async_reset_n = 1'b1;
        end
    end
endmodule // dffsc_board

`default_nettype wire

/* tb/dffsc_top_tb_top.sv */
// Self-checking testbench for the dual set/clear storage element block
`timescale 1ns/10ps
`default_nettype none
`include "dffsc_consts.svh"

module dffsc_top_tb_top
    import dffsc_pkg::*;
;
    logic                                 clock;
    logic                                 rst;
    logic                                 allow_both;
    dffsc_pins_type [`DFFSC_NUM_ELEM-1:0] req;
    dffsc_pins_type [`DFFSC_NUM_ELEM-1:0] elem_in;
    dffsc_outs_type [`DFFSC_NUM_ELEM-1:0] elem_out;
    int                                   miscompares = 0;
    int                                   checked = 0;

    dffsc_top i_dffsc_top (.clock(clock), .rst(rst), .elem_in(elem_in), .elem_out(elem_out));

    // One board model per element; only allow_both is shared between them
    for (genvar e = 0; e < `DFFSC_NUM_ELEM; e++) begin : g_board
        dffsc_board i_dffsc_board (.req(req[e]),
                                   .allow_both(allow_both), .pins(elem_in[e]));
    end

    // ****************************************************************
    // Helpers
    // ****************************************************************
    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end

    // Inputs always move 1 ns after the edge, away from sampling
    task automatic step(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    // Wide enough for both elements at once; single-element values are zero-padded
    task automatic check(input logic [3:0] seen, input logic [3:0] exp, input string what);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED %0t %s", $time, what);
        end
    endtask

    task automatic wrap_up();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic t_capture();
        logic d;
        for (int k = 0; k < 3; k++) begin
            d = ~k[0];
            req[0] = {1'b0, d, 2'b11};
            step(1);
            req[0] = {1'b1, d, 2'b11};
            step(1);
            check(elem_out[0], {d, ~d}, "capture");
            check(elem_out[1], 2'b01, "other element moved");
        end
        $display("test capture done");
    endtask

    // Data moves while the clock pin stays high, then the clock pin drops with data held
    task automatic t_hold();
        req[0] = 4'b1011;
        step(3);
        check(elem_out[0], 2'b10, "hold high clock");
        req[0] = 4'b0011;
        step(2);
        check(elem_out[0], 2'b10, "hold low clock");
        $display("test hold done");
    endtask

    // Overrides win even against a clock edge in the same cycle
    task automatic t_overrides();
        req[0] = 4'b1110;
        step(1);
        check(elem_out[0], 2'b01, "clear");
        req[0] = 4'b0111;
        step(1);
        check(elem_out[0], 2'b01, "after clear");
        req[0] = 4'b1001;
        step(1);
        check(elem_out[0], 2'b10, "set");
        req[0] = 4'b1011;
        step(1);
        check(elem_out[0], 2'b10, "after set");
        allow_both = 1'b1;
        req[0] = 4'b0000;
        step(1);
        check(elem_out[0], 2'b11, "both low");
        req[0] = 4'b0011;
        step(1);
        allow_both = 1'b0;
        check(elem_out[0], 2'b10, "after both");
        $display("test overrides done");
    endtask

    // Element 1 captures while element 0 sits in clear
    task automatic t_independent();
        req[0] = 4'b0010;
        req[1] = 4'b0111;
        step(1);
        req[1] = 4'b1111;
        step(1);
        check(elem_out[1], 2'b10, "element 1 capture");
        check(elem_out[0], 2'b01, "element 0 clear");
        rst = 1'b1;
        step(2);
        rst = 1'b0;
        check(elem_out, 4'b0101, "second reset");
        // Clock pin already high at release must not count as an edge
        req[0] = 4'b0011;
        step(1);
        check(elem_out[1], 2'b01, "no edge at release");
        // Element 1 set while element 0 idles
        req[1] = 4'b1101;
        step(2);
        check(elem_out[1], 2'b10, "element 1 set");
        check(elem_out[0], 2'b01, "element 0 untouched");
        $display("test independent done");
    endtask

    // ****************************************************************
    // Main sequence and watchdog
    // ****************************************************************
    initial begin
        rst = 1'b1;
        allow_both = 1'b0;
        req = {4'b0011, 4'b0011};
        step(5);
        rst = 1'b0;
        check(elem_out, 4'b0101, "reset value");
        t_capture();
        t_hold();
        t_overrides();
        t_independent();
        wrap_up();
    end

    // Tests need well under 100 cycles; 500 cycles means a hang
    initial begin
        #50000;
        miscompares++;
        wrap_up();
    end
endmodule // dffsc_top_tb_top

`default_nettype wire
